// ### hdl/exec_pkg.sv
// Purpose: shared types and constants of the arithmetic and branch execution unit
// Assumes: one clock, 8-bit data, 16-bit program counter
// Notes:   cycle counts are per instruction
package exec_pkg;

  typedef enum logic [5:0] {
    OP_REG_ADD             = 6'h00, OP_CARRY_ADD          = 6'h01, OP_WORD_IMM_ADD     = 6'h02,
    OP_REG_MINUS           = 6'h03, OP_IMM_MINUS          = 6'h04, OP_MINUS_WITH_BORROW = 6'h05,
    OP_IMM_MINUS_BORROW    = 6'h06, OP_WORD_IMM_MINUS     = 6'h07, OP_REG_BIT_CONJ     = 6'h08,
    OP_IMM_BIT_CONJ        = 6'h09, OP_REG_BIT_DISJ       = 6'h0A, OP_IMM_BIT_DISJ     = 6'h0B,
    OP_BIT_XOR_OP          = 6'h0C, OP_ONES_INV           = 6'h0D, OP_TWOS_INVERT      = 6'h0E,
    OP_MASK_SET_OP         = 6'h0F, OP_MASK_CLEAR_OP      = 6'h10, OP_PLUS_ONE         = 6'h11,
    OP_MINUS_ONE           = 6'h12, OP_ZERO_NEG_TEST      = 6'h13, OP_ZERO_FILL        = 6'h14,
    OP_ONES_FILL           = 6'h15, OP_REL_JUMP           = 6'h16, OP_PTR_JUMP         = 6'h17,
    OP_REL_CALL            = 6'h18, OP_PTR_CALL           = 6'h19, OP_SUB_EXIT         = 6'h1A,
    OP_IRQ_EXIT            = 6'h1B, OP_EQUAL_SKIP         = 6'h1C, OP_COMPARE_OP       = 6'h1D,
    OP_COMPARE_WITH_BORROW = 6'h1E, OP_IMM_COMPARE        = 6'h1F, OP_IO_BIT_SET       = 6'h20,
    OP_IO_BIT_CLEAR        = 6'h21, OP_IO_BIT_HIGH_SKIP   = 6'h22, OP_IO_BIT_LOW_SKIP  = 6'h23,
    OP_IO_STORE            = 6'h24, OP_IO_FETCH           = 6'h25, OP_IMM_LOAD         = 6'h26
  } op_type;

  typedef enum logic [2:0] {
    ALU_SUM  = 3'h0, ALU_DIFF = 3'h1, ALU_CONJ = 3'h2, ALU_DISJ = 3'h3,
    ALU_XOR  = 3'h4, ALU_INV  = 3'h5, ALU_PASS = 3'h6
  } alu_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_BUSY = 1'h1
  } state_type;

  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;

  // Status register bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 3;
  localparam int SR_S = 4;
  localparam int SR_H = 5;
  localparam int SR_I = 7;

  localparam logic [7:0] MASK_ARITH = 8'h3F;
  localparam logic [7:0] MASK_LOGIC = 8'h1E;
  localparam logic [7:0] MASK_INV   = 8'h1F;
  localparam logic [7:0] MASK_WORD  = 8'h1F;
  localparam logic [7:0] MASK_NONE  = 8'h00;

  localparam logic [7:0]  SREG_RST = 8'h00;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [7:0]  IO_RST   = 8'h00;

  localparam logic [5:0] IO_BIT_LIMIT   = 6'h1F;
  localparam logic [4:0] IO_STATUS_ADDR = 5'h08;
  localparam logic [4:0] IO_CTRL_ADDR   = 5'h09;
  localparam logic [7:0] IO_STATUS_W1C  = 8'hF0;
  localparam logic [4:0] PTR_LO_IDX     = 5'h1E;
  localparam logic [4:0] PTR_HI_IDX     = 5'h1F;

  localparam int STACK_DEPTH = 16;
  localparam int SP_W        = 4;

endpackage

// ### hdl/exec_alu.sv
// Purpose: 8-bit combinational ALU stage with carry, half-carry, overflow
// Assumes: caller derives zero and negative from o_res
// Notes:   o_c is the borrow for the difference kind
`timescale 1ns/1ps
`default_nettype none
module exec_alu (
  input  wire exec_pkg::alu_type i_kind,
  input  wire logic [7:0]        i_a,
  input  wire logic [7:0]        i_b,
  input  wire logic              i_cin,
  output logic      [7:0]        o_res,
  output logic                   o_h,
  output logic                   o_v,
  output logic                   o_c
);
  logic [8:0] sum_w;
  logic       a3, b3, r3, a7, b7, r7;

  always_comb begin
    sum_w = 9'h000;
    o_res = 8'h00;
    o_h   = 1'b0;
    o_v   = 1'b0;
    o_c   = 1'b0;
    case (i_kind)
      exec_pkg::ALU_SUM: begin
        sum_w = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
        o_res = sum_w[7:0];
        o_h   = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
        o_v   = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
        o_c   = sum_w[8];
      end
      exec_pkg::ALU_DIFF: begin
        sum_w = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
        o_res = sum_w[7:0];
        o_h   = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
        o_v   = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
        o_c   = sum_w[8];
      end
      exec_pkg::ALU_CONJ: o_res = i_a & i_b;
      exec_pkg::ALU_DISJ: o_res = i_a | i_b;
      exec_pkg::ALU_XOR:  o_res = i_a ^ i_b;
      exec_pkg::ALU_INV: begin
        o_res = 8'hFF - i_a;
        o_c   = 1'b1;
      end
      exec_pkg::ALU_PASS: o_res = i_b;
      default:            o_res = 8'h00;
    endcase
  end

  assign a3 = i_a[3];
  assign b3 = i_b[3];
  assign r3 = sum_w[3];
  assign a7 = i_a[7];
  assign b7 = i_b[7];
  assign r7 = sum_w[7];

endmodule
`default_nettype wire

// ### hdl/exec_core.sv
// Purpose: execution unit for ALU, word, compare, branch and I/O bit instructions
// Assumes: i_valid offers one instruction, taken while o_ready is high
// Notes:   architectural state changes at the taking edge; o_ready stays low for the rest of
//          the instruction's cycle count and o_done marks its last cycle
//
// Overview of operation
// - Add with carry: Rd+Rr+C, six flags, one clock
// - Word immediate add on pair, two clocks
// - Immediate subtract into register, one clock
// - Register subtract with borrow, one clock
// - Immediate subtract with borrow, one clock
// - Word immediate subtract on pair, two clocks
// - Immediate AND, only Z N V S change
// - Immediate OR, only Z N V S change
// - Mask set ORs immediate into register
// - Mask clear ANDs with 0xFF minus mask
// - Test ANDs register with itself, no write
// - Pointer jump loads PC from pair, two clocks
// - Pointer call pushes return, three clocks
// - Immediate compare sets flags, stores nothing
// - Equal skip steps over next instruction
// - Bit access only at I/O 0x00..0x1F
// - Bit set/clear touch only addressed bit
// - Some status flags clear on written one
`timescale 1ns/1ps
`default_nettype none
module exec_core (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_valid,
  input  wire exec_pkg::op_type     i_op,
  input  wire logic [4:0]           i_rd_idx,
  input  wire logic [4:0]           i_rr_idx,
  input  wire logic [7:0]           i_imm,
  input  wire logic [11:0]          i_rel_off,
  input  wire logic [5:0]           i_io_addr,
  input  wire logic [2:0]           i_bit_idx,
  input  wire logic                 i_next_two_word,
  input  wire logic [7:0]           i_flag_set,
  input  wire logic [4:0]           i_peek_idx,
  output logic                      o_ready,
  output logic                      o_done,
  output logic                      o_bad_addr,
  output logic [15:0]               o_pc,
  output logic [7:0]                o_sreg,
  output logic [exec_pkg::SP_W-1:0] o_sp,
  output logic [7:0]                o_peek_data,
  output logic [7:0]                o_io_status,
  output logic [7:0]                o_io_ctrl
);

  // Only the status byte holds flags that clear on a written one
  function automatic logic [7:0] w1c_of(input logic [4:0] addr);
    w1c_of = (addr == exec_pkg::IO_STATUS_ADDR) ? exec_pkg::IO_STATUS_W1C : 8'h00;
  endfunction

  // Writes only the selected bits; a one on a clear-on-one bit clears it
  function automatic logic [7:0] io_apply(input logic [7:0] old, input logic [7:0] data,
                                          input logic [7:0] sel, input logic [7:0] w1c);
    logic [7:0] plain;
    plain    = sel & ~w1c;
    io_apply = (old & ~plain) | (data & plain);
    io_apply = io_apply & ~(data & sel & w1c);
  endfunction

  logic [7:0]                gpr_r [32];
  logic [7:0]                io_r [32];
  logic [7:0]                io_nxt [32];
  logic [15:0]               stack_r [exec_pkg::STACK_DEPTH];
  logic [exec_pkg::SP_W-1:0] sp_r, sp_nxt;
  logic [15:0]               pc_r, pc_nxt;
  logic [7:0]                sreg_r, sreg_nxt;
  logic [7:0]                peek_r, peek_nxt;
  logic                      ready_r, ready_nxt;
  logic                      done_r, done_nxt;
  logic                      bad_r, bad_nxt;
  exec_pkg::state_type       state_r, state_nxt;
  logic [2:0]                cnt_r, cnt_nxt;

  exec_pkg::alu_type         kind;
  logic [7:0]                a_op, b_op, alu_res;
  logic                      cin, alu_h, alu_v, alu_c;
  logic                      accept, word_op, chain_z, skip, push, pop, set_i, bad;
  logic                      wr_lo, wr_hi, io_wr;
  logic [7:0]                wr_lo_data, wr_hi_data, mask, cand, io_data, io_sel;
  logic [15:0]               pair, word_res, ptr, ret_addr, rel_tgt;
  logic [2:0]                cyc;
  logic                      fl_z, fl_n, fl_v, fl_c, fl_h, io_ok;
  logic [4:0]                rd_hi_idx;

  exec_alu u_alu (
    .i_kind (kind),
    .i_a    (a_op),
    .i_b    (b_op),
    .i_cin  (cin),
    .o_res  (alu_res),
    .o_h    (alu_h),
    .o_v    (alu_v),
    .o_c    (alu_c)
  );

  assign accept    = i_valid && ready_r && (state_r == exec_pkg::ST_IDLE);
  assign rd_hi_idx = i_rd_idx + 5'h01;
  assign pair      = {gpr_r[rd_hi_idx], gpr_r[i_rd_idx]};
  assign ptr       = {gpr_r[exec_pkg::PTR_HI_IDX], gpr_r[exec_pkg::PTR_LO_IDX]};
  assign ret_addr  = pc_r + 16'h0001;
  assign rel_tgt   = pc_r + {{4{i_rel_off[11]}}, i_rel_off} + 16'h0001;
  // Reserved addresses are refused, never written
  assign io_ok     = (i_io_addr <= exec_pkg::IO_BIT_LIMIT);

  // Instruction decode and datapath
  always_comb begin
    kind       = exec_pkg::ALU_SUM;
    a_op       = gpr_r[i_rd_idx];
    b_op       = gpr_r[i_rr_idx];
    cin        = 1'b0;
    word_op    = 1'b0;
    word_res   = 16'h0000;
    chain_z    = 1'b0;
    wr_lo      = 1'b0;
    wr_hi      = 1'b0;
    wr_lo_data = alu_res;
    wr_hi_data = 8'h00;
    mask       = exec_pkg::MASK_NONE;
    cyc        = exec_pkg::CYC_ONE;
    pc_nxt     = ret_addr;
    skip       = 1'b0;
    push       = 1'b0;
    pop        = 1'b0;
    set_i      = 1'b0;
    bad        = 1'b0;
    io_wr      = 1'b0;
    io_sel     = 8'h00;
    io_data    = 8'h00;
    case (i_op)
      exec_pkg::OP_REG_ADD: begin
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_ARITH;
      end
      exec_pkg::OP_CARRY_ADD: begin
        cin   = sreg_r[exec_pkg::SR_C];
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_ARITH;
      end
      exec_pkg::OP_REG_MINUS, exec_pkg::OP_IMM_MINUS: begin
        kind  = exec_pkg::ALU_DIFF;
        b_op  = (i_op == exec_pkg::OP_IMM_MINUS) ? i_imm : gpr_r[i_rr_idx];
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_ARITH;
      end
      exec_pkg::OP_MINUS_WITH_BORROW, exec_pkg::OP_IMM_MINUS_BORROW: begin
        kind    = exec_pkg::ALU_DIFF;
        b_op    = (i_op == exec_pkg::OP_IMM_MINUS_BORROW) ? i_imm : gpr_r[i_rr_idx];
        cin     = sreg_r[exec_pkg::SR_C];
        chain_z = 1'b1;
        wr_lo   = 1'b1;
        mask    = exec_pkg::MASK_ARITH;
      end
      exec_pkg::OP_WORD_IMM_ADD, exec_pkg::OP_WORD_IMM_MINUS: begin
        word_op    = 1'b1;
        word_res   = (i_op == exec_pkg::OP_WORD_IMM_ADD) ? pair + {10'h000, i_imm[5:0]}
                                                        : pair - {10'h000, i_imm[5:0]};
        wr_lo      = 1'b1;
        wr_hi      = 1'b1;
        wr_lo_data = word_res[7:0];
        wr_hi_data = word_res[15:8];
        mask       = exec_pkg::MASK_WORD;
        cyc        = exec_pkg::CYC_TWO;
      end
      exec_pkg::OP_REG_BIT_CONJ, exec_pkg::OP_IMM_BIT_CONJ: begin
        kind  = exec_pkg::ALU_CONJ;
        b_op  = (i_op == exec_pkg::OP_IMM_BIT_CONJ) ? i_imm : gpr_r[i_rr_idx];
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_LOGIC;
      end
      exec_pkg::OP_REG_BIT_DISJ, exec_pkg::OP_IMM_BIT_DISJ, exec_pkg::OP_MASK_SET_OP: begin
        kind  = exec_pkg::ALU_DISJ;
        b_op  = (i_op == exec_pkg::OP_REG_BIT_DISJ) ? gpr_r[i_rr_idx] : i_imm;
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_LOGIC;
      end
      exec_pkg::OP_MASK_CLEAR_OP: begin
        kind  = exec_pkg::ALU_CONJ;
        b_op  = 8'hFF - i_imm;
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_LOGIC;
      end
      exec_pkg::OP_BIT_XOR_OP, exec_pkg::OP_ZERO_FILL: begin
        kind  = exec_pkg::ALU_XOR;
        b_op  = (i_op == exec_pkg::OP_ZERO_FILL) ? gpr_r[i_rd_idx] : gpr_r[i_rr_idx];
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_LOGIC;
      end
      exec_pkg::OP_ONES_INV: begin
        kind  = exec_pkg::ALU_INV;
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_INV;
      end
      exec_pkg::OP_TWOS_INVERT: begin
        kind  = exec_pkg::ALU_DIFF;
        a_op  = 8'h00;
        b_op  = gpr_r[i_rd_idx];
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_ARITH;
      end
      exec_pkg::OP_PLUS_ONE, exec_pkg::OP_MINUS_ONE: begin
        kind  = (i_op == exec_pkg::OP_PLUS_ONE) ? exec_pkg::ALU_SUM : exec_pkg::ALU_DIFF;
        b_op  = 8'h01;
        wr_lo = 1'b1;
        mask  = exec_pkg::MASK_LOGIC;
      end
      exec_pkg::OP_ZERO_NEG_TEST: begin
        kind = exec_pkg::ALU_CONJ;
        b_op = gpr_r[i_rd_idx];
        mask = exec_pkg::MASK_LOGIC;
      end
      exec_pkg::OP_ONES_FILL, exec_pkg::OP_IMM_LOAD: begin
        kind  = exec_pkg::ALU_PASS;
        b_op  = (i_op == exec_pkg::OP_ONES_FILL) ? 8'hFF : i_imm;
        wr_lo = 1'b1;
      end
      exec_pkg::OP_COMPARE_OP, exec_pkg::OP_IMM_COMPARE: begin
        kind = exec_pkg::ALU_DIFF;
        b_op = (i_op == exec_pkg::OP_IMM_COMPARE) ? i_imm : gpr_r[i_rr_idx];
        mask = exec_pkg::MASK_ARITH;
      end
      exec_pkg::OP_COMPARE_WITH_BORROW: begin
        kind    = exec_pkg::ALU_DIFF;
        cin     = sreg_r[exec_pkg::SR_C];
        chain_z = 1'b1;
        mask    = exec_pkg::MASK_ARITH;
      end
      exec_pkg::OP_REL_JUMP: begin
        pc_nxt = rel_tgt;
        cyc    = exec_pkg::CYC_TWO;
      end
      exec_pkg::OP_PTR_JUMP: begin
        pc_nxt = ptr;
        cyc    = exec_pkg::CYC_TWO;
      end
      exec_pkg::OP_REL_CALL, exec_pkg::OP_PTR_CALL: begin
        pc_nxt = (i_op == exec_pkg::OP_PTR_CALL) ? ptr : rel_tgt;
        push   = 1'b1;
        cyc    = exec_pkg::CYC_THREE;
      end
      exec_pkg::OP_SUB_EXIT, exec_pkg::OP_IRQ_EXIT: begin
        pc_nxt = stack_r[sp_r - 4'h1];
        pop    = 1'b1;
        set_i  = (i_op == exec_pkg::OP_IRQ_EXIT);
        cyc    = exec_pkg::CYC_FOUR;
      end
      exec_pkg::OP_EQUAL_SKIP: skip = (gpr_r[i_rd_idx] == gpr_r[i_rr_idx]);
      exec_pkg::OP_IO_BIT_SET, exec_pkg::OP_IO_BIT_CLEAR: begin
        bad     = !io_ok;
        io_wr   = io_ok;
        io_sel  = 8'h01 << i_bit_idx;
        io_data = (i_op == exec_pkg::OP_IO_BIT_SET) ? io_sel : 8'h00;
        cyc     = exec_pkg::CYC_TWO;
      end
      exec_pkg::OP_IO_BIT_HIGH_SKIP, exec_pkg::OP_IO_BIT_LOW_SKIP: begin
        bad  = !io_ok;
        skip = io_ok && (io_r[i_io_addr[4:0]][i_bit_idx] == (i_op == exec_pkg::OP_IO_BIT_HIGH_SKIP));
      end
      exec_pkg::OP_IO_STORE: begin
        bad     = !io_ok;
        io_wr   = io_ok;
        io_sel  = 8'hFF;
        io_data = gpr_r[i_rd_idx];
      end
      exec_pkg::OP_IO_FETCH: begin
        bad        = !io_ok;
        wr_lo      = io_ok;
        wr_lo_data = io_r[i_io_addr[4:0]];
      end
      default: bad = 1'b0;
    endcase
    // Skip length follows the skipped instruction's size
    if (skip) begin
      pc_nxt = pc_r + (i_next_two_word ? 16'h0003 : 16'h0002);
      cyc    = i_next_two_word ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO;
    end
  end

  // Flag candidates
  always_comb begin
    if (word_op) begin
      fl_c = (i_op == exec_pkg::OP_WORD_IMM_ADD) ? (~word_res[15] & pair[15])
                                                 : (word_res[15] & ~pair[15]);
      fl_v = (i_op == exec_pkg::OP_WORD_IMM_ADD) ? (~pair[15] & word_res[15])
                                                 : (pair[15] & ~word_res[15]);
      fl_n = word_res[15];
      fl_z = (word_res == 16'h0000);
      fl_h = sreg_r[exec_pkg::SR_H];
    end else begin
      fl_c = alu_c;
      fl_v = alu_v;
      fl_n = alu_res[7];
      // Borrow forms keep Z cleared once an earlier byte was nonzero
      fl_z = (alu_res == 8'h00) && (!chain_z || sreg_r[exec_pkg::SR_Z]);
      fl_h = alu_h;
    end
    cand     = {sreg_r[7:6], fl_h, fl_n ^ fl_v, fl_v, fl_n, fl_z, fl_c};
    sreg_nxt = sreg_r;
    if (accept) begin
      sreg_nxt = (sreg_r & ~mask) | (cand & mask);
      if (set_i) begin
        sreg_nxt[exec_pkg::SR_I] = 1'b1;
      end
    end
  end

  // I/O bytes; a flag set beats a same-cycle clear
  always_comb begin
    for (int k = 0; k < 32; k++) begin
      io_nxt[k] = io_r[k];
      if (accept && io_wr && (i_io_addr[4:0] == 5'(k))) begin
        io_nxt[k] = io_apply(io_r[k], io_data, io_sel, w1c_of(5'(k)));
      end
    end
    io_nxt[exec_pkg::IO_STATUS_ADDR] = io_nxt[exec_pkg::IO_STATUS_ADDR]
                                       | (i_flag_set & exec_pkg::IO_STATUS_W1C);
  end

  // Sequencing and program counter
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ready_nxt = ready_r;
    done_nxt  = 1'b0;
    bad_nxt   = 1'b0;
    sp_nxt    = sp_r;
    peek_nxt  = gpr_r[i_peek_idx];
    case (state_r)
      exec_pkg::ST_IDLE: begin
        if (accept) begin
          bad_nxt = bad;
          if (push) begin
            sp_nxt = sp_r + 4'h1;
          end else if (pop) begin
            sp_nxt = sp_r - 4'h1;
          end
          if (cyc == exec_pkg::CYC_ONE) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = exec_pkg::ST_BUSY;
            cnt_nxt   = cyc - exec_pkg::CYC_ONE;
            ready_nxt = 1'b0;
          end
        end
      end
      exec_pkg::ST_BUSY: begin
        cnt_nxt = cnt_r - exec_pkg::CYC_ONE;
        if (cnt_r == exec_pkg::CYC_ONE) begin
          state_nxt = exec_pkg::ST_IDLE;
          ready_nxt = 1'b1;
          done_nxt  = 1'b1;
        end
      end
      default: begin
        state_nxt = exec_pkg::ST_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= exec_pkg::ST_IDLE;
      cnt_r   <= 3'h0;
      ready_r <= 1'b1;
      done_r  <= 1'b0;
      bad_r   <= 1'b0;
      pc_r    <= exec_pkg::PC_RST;
      sreg_r  <= exec_pkg::SREG_RST;
      sp_r    <= '0;
      peek_r  <= 8'h00;
      for (int k = 0; k < 32; k++) begin
        gpr_r[k] <= 8'h00;
        io_r[k]  <= exec_pkg::IO_RST;
      end
      for (int k = 0; k < exec_pkg::STACK_DEPTH; k++) begin
        stack_r[k] <= 16'h0000;
      end
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ready_r <= ready_nxt;
      done_r  <= done_nxt;
      bad_r   <= bad_nxt;
      sreg_r  <= sreg_nxt;
      sp_r    <= sp_nxt;
      peek_r  <= peek_nxt;
      io_r    <= io_nxt;
      if (accept) begin
        pc_r <= pc_nxt;
      end
      if (accept && wr_lo) begin
        gpr_r[i_rd_idx] <= wr_lo_data;
      end
      if (accept && wr_hi) begin
        gpr_r[rd_hi_idx] <= wr_hi_data;
      end
      // Stack wraps silently past STACK_DEPTH calls
      if (accept && push) begin
        stack_r[sp_r] <= ret_addr;
      end
    end
  end

  assign o_ready     = ready_r;
  assign o_done      = done_r;
  assign o_bad_addr  = bad_r;
  assign o_pc        = pc_r;
  assign o_sreg      = sreg_r;
  assign o_sp        = sp_r;
  assign o_peek_data = peek_r;
  assign o_io_status = io_r[exec_pkg::IO_STATUS_ADDR];
  assign o_io_ctrl   = io_r[exec_pkg::IO_CTRL_ADDR];

endmodule
`default_nettype wire

// ### dv/exec_core_monitor.sv
// Purpose: timing, flag and PC checks of exec_core
// Assumes: top-level ports only; async active-low reset
// Notes:   every count starts at the edge that takes the instruction
`timescale 1ns/1ps
`default_nettype none
module exec_core_monitor (
  input wire logic                      i_clk,
  input wire logic                      i_rst_n,
  input wire logic                      i_valid,
  input wire exec_pkg::op_type          i_op,
  input wire logic [5:0]                i_io_addr,
  input wire logic                      o_ready,
  input wire logic                      o_done,
  input wire logic                      o_bad_addr,
  input wire logic [15:0]               o_pc,
  input wire logic [7:0]                o_sreg,
  input wire logic [exec_pkg::SP_W-1:0] o_sp
);
  logic tk;
  assign tk = i_valid && o_ready;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence two_s;
    !o_ready ##1 o_done;
  endsequence
  sequence three_s;
    !o_ready [*2] ##1 o_done;
  endsequence
  arith_one_clk_a: assert property (tk && i_op inside {exec_pkg::OP_CARRY_ADD, exec_pkg::OP_IMM_MINUS,
    exec_pkg::OP_MINUS_WITH_BORROW, exec_pkg::OP_IMM_MINUS_BORROW} |=> o_done && o_ready)
    else $error("arithmetic op not one clock");
  word_two_clk_a: assert property (tk && i_op inside {exec_pkg::OP_WORD_IMM_ADD, exec_pkg::OP_WORD_IMM_MINUS}
    |=> two_s) else $error("word op not two clocks");
  logic_keep_a: assert property (tk && i_op inside {exec_pkg::OP_IMM_BIT_CONJ, exec_pkg::OP_IMM_BIT_DISJ,
    exec_pkg::OP_MASK_SET_OP, exec_pkg::OP_MASK_CLEAR_OP, exec_pkg::OP_ZERO_NEG_TEST} |=> o_done
    && o_sreg[0] == $past(o_sreg[0]) && o_sreg[5] == $past(o_sreg[5])) else $error("logic op touched carry");
  ptr_jump_a: assert property (tk && i_op == exec_pkg::OP_PTR_JUMP |=> o_sreg == $past(o_sreg) ##0 two_s)
    else $error("pointer jump timing or flags wrong");
  ptr_call_a: assert property (tk && i_op == exec_pkg::OP_PTR_CALL |=> o_sp == $past(o_sp) + 1'b1 ##0 three_s)
    else $error("pointer call push or timing wrong");
  compare_pc_a: assert property (tk && i_op == exec_pkg::OP_IMM_COMPARE
    |=> o_done && o_pc == $past(o_pc) + 16'h0001) else $error("compare did not step once");
  skip_bound_a: assert property (tk && i_op == exec_pkg::OP_EQUAL_SKIP
    |=> o_sreg == $past(o_sreg) ##[0:2] o_done) else $error("equal skip too long or changed flags");
  bad_addr_a: assert property (tk && i_op == exec_pkg::OP_IO_BIT_LOW_SKIP && i_io_addr > 6'h1F
    |=> o_bad_addr && o_done) else $error("reserved bit address not refused");
endmodule
bind exec_core exec_core_monitor u_mon (.i_clk, .i_rst_n, .i_valid, .i_op, .i_io_addr, .o_ready, .o_done,
  .o_bad_addr, .o_pc, .o_sreg, .o_sp);
`default_nettype wire

// ### dv/tb_cpu_arith_branch_exec.sv
// Purpose: self-checking bench for exec_core
// Assumes: seed 31; random operands from r16..r29
// Notes:   a shadow register file and flag byte predict every result
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_arith_branch_exec;
  logic                      i_clk, i_rst_n, v, nt, rdy, dn, bad;
  exec_pkg::op_type          op, o;
  logic [4:0]                rd, rr, pk, d, s;
  logic [7:0]                imm, fs, sr, ios, ioc, pd, es, k;
  logic [7:0]                g [32];
  logic [5:0]                ioa;
  logic [2:0]                bi;
  logic [11:0]               off;
  logic [15:0]               pc, ep, w, x;
  logic [exec_pkg::SP_W-1:0] sp;
  int                        fails, total_checks, i;
  exec_pkg::op_type ops [10] = '{exec_pkg::OP_CARRY_ADD, exec_pkg::OP_IMM_MINUS, exec_pkg::OP_MINUS_WITH_BORROW,
    exec_pkg::OP_IMM_MINUS_BORROW, exec_pkg::OP_IMM_BIT_CONJ, exec_pkg::OP_IMM_BIT_DISJ, exec_pkg::OP_MASK_SET_OP,
    exec_pkg::OP_MASK_CLEAR_OP, exec_pkg::OP_ZERO_NEG_TEST, exec_pkg::OP_IMM_COMPARE};
  exec_core DUT (.i_clk, .i_rst_n, .i_valid(v), .i_op(op), .i_rd_idx(rd), .i_rr_idx(rr), .i_imm(imm),
    .i_rel_off(off), .i_io_addr(ioa), .i_bit_idx(bi), .i_next_two_word(nt), .i_flag_set(fs), .i_peek_idx(pk),
    .o_ready(rdy), .o_done(dn), .o_bad_addr(bad), .o_pc(pc), .o_sreg(sr), .o_sp(sp), .o_peek_data(pd),
    .o_io_status(ios), .o_io_ctrl(ioc));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic print_verdict;
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Returns {flags, result}
  function automatic logic [15:0] alu(input exec_pkg::op_type o, input logic [7:0] a, s, k, f);
    logic [7:0] b, r, e, q, bb;
    logic       c, h, vv, z, ad, lg;
    ad = (o == exec_pkg::OP_CARRY_ADD);
    lg = o inside {exec_pkg::OP_IMM_BIT_CONJ, exec_pkg::OP_IMM_BIT_DISJ, exec_pkg::OP_MASK_SET_OP,
      exec_pkg::OP_MASK_CLEAR_OP, exec_pkg::OP_ZERO_NEG_TEST};
    b = (ad || o == exec_pkg::OP_MINUS_WITH_BORROW) ? s : k;
    if (o == exec_pkg::OP_MASK_CLEAR_OP) b = 8'hFF - k;
    if (o == exec_pkg::OP_ZERO_NEG_TEST) b = a;
    case (o)
      exec_pkg::OP_CARRY_ADD: r = a + b + 8'(f[0]);
      exec_pkg::OP_MINUS_WITH_BORROW, exec_pkg::OP_IMM_MINUS_BORROW: r = a - b - 8'(f[0]);
      exec_pkg::OP_IMM_BIT_DISJ, exec_pkg::OP_MASK_SET_OP: r = a | b;
      default: r = lg ? (a & b) : (a - b);
    endcase
    e = ad ? a : ~a;
    q = ad ? ~r : r;
    bb = ad ? b : ~b;
    c = e[7] & b[7] | b[7] & q[7] | q[7] & e[7];
    h = e[3] & b[3] | b[3] & q[3] | q[3] & e[3];
    vv = a[7] & bb[7] & ~r[7] | ~a[7] & ~bb[7] & r[7];
    z = (r == 8'h00);
    if (o == exec_pkg::OP_MINUS_WITH_BORROW || o == exec_pkg::OP_IMM_MINUS_BORROW) z = z & f[1];
    if (lg) {c, h, vv} = {f[0], f[5], 1'b0};
    return {f[7:6], h, r[7] ^ vv, vv, r[7], z, c, r};
  endfunction
  task automatic ex(input exec_pkg::op_type c, input logic [4:0] a, b, input logic [7:0] kk,
                    input logic [9:0] io, input int n, input logic [15:0] np);
    int m;
    @(posedge i_clk);
    op <= c;
    {v, rd, rr, imm, nt, bi, ioa, pk} <= {1'b1, a, b, kk, io, a};
    @(posedge i_clk);
    v <= 1'b0;
    for (m = 1; m < 6; m++) begin
      #1;
      if (dn === 1'b1) break;
      @(posedge i_clk);
    end
    @(posedge i_clk);
    #1;
    chk(16'(m), 16'(n));
    chk(pc, np);
    chk(16'(sr), 16'(es));
    chk(16'(pd), 16'(g[a]));
    ep = np;
  endtask
  task automatic ld(input logic [4:0] a, input logic [7:0] b);
    g[a] = b;
    ex(exec_pkg::OP_IMM_LOAD, a, 5'd0, b, 10'h000, 1, ep + 16'h0001);
  endtask
  initial begin
    #40000;
    fails++;
    print_verdict;
  end
  initial begin
    {i_rst_n, v, nt, bi, ioa, fs, pk, rd, rr, imm, es, ep} = '0;
    op = exec_pkg::OP_IMM_LOAD;
    off = 12'hFF0;
    for (i = 0; i < 32; i++) g[i] = 8'h00;
    i = $urandom(31);
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (i = 16; i < 32; i++) ld(5'(i), 8'($urandom));
    for (i = 0; i < 40; i++) begin
      o = ops[$urandom % 10];
      d = 5'(16 + $urandom % 14);
      s = 5'(16 + $urandom % 14);
      k = 8'($urandom);
      {es, x[7:0]} = alu(o, g[d], g[s], k, es);
      if (o != exec_pkg::OP_IMM_COMPARE) g[d] = x[7:0];
      ex(o, d, s, k, 10'h000, 1, ep + 16'h0001);
    end
    ld(5'd24, 8'hE0);
    ld(5'd25, 8'hFF);
    w = 16'hFFE0;
    x = w + 16'h003F;
    {g[25], g[24]} = x;
    es[4:0] = {x[15] ^ (~w[15] & x[15]), ~w[15] & x[15], x[15], x == 16'h0000, ~x[15] & w[15]};
    ex(exec_pkg::OP_WORD_IMM_ADD, 5'd24, 5'd0, 8'h3F, 10'h000, 2, ep + 16'h0001);
    {g[25], g[24]} = w;
    es[4:0] = {w[15] ^ (x[15] & ~w[15]), x[15] & ~w[15], w[15], w == 16'h0000, w[15] & ~x[15]};
    ex(exec_pkg::OP_WORD_IMM_MINUS, 5'd24, 5'd0, 8'h3F, 10'h000, 2, ep + 16'h0001);
    ld(5'd30, 8'h34);
    ld(5'd31, 8'h12);
    x = ep + 16'h0001;
    ex(exec_pkg::OP_PTR_CALL, 5'd0, 5'd0, 8'h00, 10'h000, 3, 16'h1234);
    chk(16'(sp), 16'h0001);
    ex(exec_pkg::OP_REL_JUMP, 5'd0, 5'd0, 8'h00, 10'h000, 2, ep + 16'hFFF1);
    ex(exec_pkg::OP_SUB_EXIT, 5'd0, 5'd0, 8'h00, 10'h000, 4, x);
    ex(exec_pkg::OP_PTR_JUMP, 5'd0, 5'd0, 8'h00, 10'h000, 2, 16'h1234);
    ex(exec_pkg::OP_EQUAL_SKIP, 5'd16, 5'd16, 8'h00, 10'h200, 3, ep + 16'h0003);
    ex(exec_pkg::OP_EQUAL_SKIP, 5'd30, 5'd31, 8'h00, 10'h000, 1, ep + 16'h0001);
    @(posedge i_clk);
    fs <= 8'hF0;
    @(posedge i_clk);
    fs <= 8'h00;
    ex(exec_pkg::OP_IO_BIT_SET, 5'd0, 5'd0, 8'h00, {1'b0, 3'd5, 6'h08}, 2, ep + 16'h0001);
    chk(16'(ios), 16'h00D0);
    ex(exec_pkg::OP_IO_BIT_SET, 5'd0, 5'd0, 8'h00, {1'b0, 3'd2, 6'h09}, 2, ep + 16'h0001);
    chk(16'(ioc), 16'h0004);
    ex(exec_pkg::OP_IO_BIT_CLEAR, 5'd0, 5'd0, 8'h00, {1'b0, 3'd2, 6'h09}, 2, ep + 16'h0001);
    chk(16'(ioc), 16'h0000);
    ex(exec_pkg::OP_IO_BIT_HIGH_SKIP, 5'd0, 5'd0, 8'h00, {1'b0, 3'd7, 6'h08}, 2, ep + 16'h0002);
    ex(exec_pkg::OP_IO_BIT_LOW_SKIP, 5'd0, 5'd0, 8'h00, {1'b0, 3'd0, 6'h28}, 1, ep + 16'h0001);
    print_verdict;
  end
endmodule
`default_nettype wire
